// ### common/pmlc_pkg.sv
// Package for the loop mode and lock control block: register map, fields,
// reset values, bus states and the packed state records of both modules.
// Assumes a 32-bit Avalon-MM slave port with byte addresses, word aligned.
package pmlc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] PMLC_PLL_CONTROL_IDX = 8'h1c;
	localparam logic [7:0] PMLC_BANDWIDTH_CONTROL_IDX = 8'h1d;
	localparam logic [7:0] PMLC_MULTIPLIER_PROGRAMMING_IDX = 8'h1e;
	localparam int PMLC_ADDR_W = 8;

	// pll_control fields
	localparam int PMLC_CTL_IRQ_EN_BIT = 7;
	localparam int PMLC_CTL_FLAG_BIT = 6;
	localparam int PMLC_CTL_POWER_BIT = 5;
	localparam int PMLC_CTL_SEL_BIT = 4;

	// bandwidth_control fields
	localparam int PMLC_BW_AUTO_BIT = 7;
	localparam int PMLC_BW_LOCK_BIT = 6;
	localparam int PMLC_BW_TRACK_BIT = 5;

	// multiplier_programming fields: N high nibble, L low nibble
	localparam int PMLC_N_LSB = 4;
	localparam int PMLC_L_LSB = 0;
	localparam int PMLC_NIB_W = 4;

	// Values after reset
	localparam logic [3:0] PMLC_N_RST = 4'h0;
	localparam logic [3:0] PMLC_L_RST = 4'h0;

	// Nominal center-of-range frequency in Hz
	localparam int unsigned PMLC_NOM_FREQ_HZ = 4915200;
	localparam int PMLC_CENTER_W = 27;

	// Lock detector counter width
	localparam int PMLC_LD_W = 8;

	// Bus answer states
	typedef enum logic [0:0]
	{
		PMLC_BUS_IDLE = 1'b0,
		PMLC_BUS_ACK = 1'b1
	} pmlc_bus_type;

	// Synchroniser state
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
	} pmlc_sync_type;

	// Whole state of the control block
	typedef struct packed
	{
		pmlc_bus_type bus;
		logic [31:0] rdata;
		logic irq_en;
		logic lock_flag;
		logic loop_on;
		logic vco_sel;
		logic auto_bw;
		logic lock;
		logic track;
		logic [3:0] mul_n;
		logic [3:0] mul_l;
		logic [3:0] fb_cnt;
		logic fb_tick;
		logic pump_up;
		logic pump_down;
		logic [PMLC_LD_W-1:0] win_refs;
		logic [PMLC_LD_W-1:0] win_fbs;
		logic [PMLC_CENTER_W-1:0] center_hz;
	} pmlc_state_type;

	localparam pmlc_sync_type PMLC_SYNC_RST = '0;
	localparam pmlc_state_type PMLC_STATE_RST = '{
		bus: PMLC_BUS_IDLE,
		mul_n: PMLC_N_RST,
		mul_l: PMLC_L_RST,
		default: '0
	};

endpackage

// ### rtl/pmlc_sync_edge.sv
// Two-flop synchroniser with rising-edge detect for one clock pin.
// Assumes the pin toggles no faster than a quarter of ref_clk.
`timescale 1ns/1ps
module pmlc_sync_edge
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Asynchronous pin
	input wire logic pin,
	// Synchronised level and edge
	output logic level,
	output logic rise
);

	pmlc_pkg::pmlc_sync_type q;
	pmlc_pkg::pmlc_sync_type d;

	// Shift chain; s1 is read only by s2
	always_comb
	begin
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			q <= pmlc_pkg::PMLC_SYNC_RST;
		else
			q <= d;
	end

	// Edge seen on the stable pair only
	assign level = q.s2;
	assign rise = q.s2 & ~q.s3;

endmodule

// ### rtl/pmlc_loop_ctrl.sv
// Control and monitoring logic of a frequency-multiplying loop: feedback
// divider, reference path, phase and lock detectors, filter mode, registers.
// Assumes vco_clock and crystal_clock pins are much slower than ref_clk and
// an Avalon-MM master with byte addresses on the register port.
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps

module pmlc_loop_ctrl
#(
	parameter logic [pmlc_pkg::PMLC_LD_W-1:0] LD_WINDOW = 8'h20,
	parameter logic [pmlc_pkg::PMLC_LD_W-1:0] TRK_TOL = 8'h02,
	parameter logic [pmlc_pkg::PMLC_LD_W-1:0] UNT_TOL = 8'h04,
	parameter logic [pmlc_pkg::PMLC_LD_W-1:0] LOCK_TOL = 8'h01,
	parameter logic [pmlc_pkg::PMLC_LD_W-1:0] UNL_TOL = 8'h03
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Avalon-MM register slave
	input wire logic [pmlc_pkg::PMLC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Clock pins from oscillator and VCO
	input wire logic crystal_clock,
	input wire logic vco_clock,
	// Loop side
	output logic final_reference_clock,
	output logic vco_feedback_clock,
	output logic pump_up,
	output logic pump_down,
	output logic filter_tracking,
	output logic loop_enable,
	output logic [pmlc_pkg::PMLC_CENTER_W-1:0] center_freq_hz,
	// Base clock selector and CPU interrupt
	output logic base_clock_source_select,
	output logic lock_change_irq
);

	pmlc_pkg::pmlc_state_type q;
	pmlc_pkg::pmlc_state_type d;
	logic ref_level;
	logic ref_rise;
	logic vco_rise;
	logic [7:0] reg_idx;
	logic [31:0] rd_mux;
	logic bus_req;

	// Reference path: buffered only, never divided
	pmlc_sync_edge u_ref_sync
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin(crystal_clock),
		.level(ref_level),
		.rise(ref_rise)
	);

	// VCO pin feeds the modulo divider
	pmlc_sync_edge u_vco_sync
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin(vco_clock),
		.level(),
		.rise(vco_rise)
	);

	assign reg_idx = {2'b00, avs_address[pmlc_pkg::PMLC_ADDR_W-1:2]};
	assign bus_req = avs_read | avs_write;

	// Read view; disabled fields read zero outside auto mode
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (reg_idx)
			pmlc_pkg::PMLC_PLL_CONTROL_IDX:
			begin
				rd_mux[pmlc_pkg::PMLC_CTL_IRQ_EN_BIT] = q.irq_en & q.auto_bw;
				rd_mux[pmlc_pkg::PMLC_CTL_FLAG_BIT] = q.lock_flag;
				rd_mux[pmlc_pkg::PMLC_CTL_POWER_BIT] = q.loop_on;
				rd_mux[pmlc_pkg::PMLC_CTL_SEL_BIT] = q.vco_sel;
			end
			pmlc_pkg::PMLC_BANDWIDTH_CONTROL_IDX:
			begin
				rd_mux[pmlc_pkg::PMLC_BW_AUTO_BIT] = q.auto_bw;
				rd_mux[pmlc_pkg::PMLC_BW_LOCK_BIT] = q.lock & q.auto_bw;
				rd_mux[pmlc_pkg::PMLC_BW_TRACK_BIT] = q.track;
			end
			pmlc_pkg::PMLC_MULTIPLIER_PROGRAMMING_IDX:
			begin
				rd_mux[pmlc_pkg::PMLC_N_LSB +: pmlc_pkg::PMLC_NIB_W] = q.mul_n;
				rd_mux[pmlc_pkg::PMLC_L_LSB +: pmlc_pkg::PMLC_NIB_W] = q.mul_l;
			end
			default:
				rd_mux = 32'h00000000;
		endcase
	end

	// Next state of the whole block
	always_comb
	begin
		logic [3:0] n_eff;
		logic loop_act;
		logic [7:0] wd;
		logic wr_ok;
		logic up_n;
		logic dn_n;
		logic [pmlc_pkg::PMLC_LD_W-1:0] fbs;
		logic [pmlc_pkg::PMLC_LD_W-1:0] diff;
		logic new_on;
		logic new_sel;
		n_eff = 4'h0;
		loop_act = 1'b0;
		wd = avs_writedata[7:0];
		wr_ok = avs_write & avs_byteenable[0];
		up_n = 1'b0;
		dn_n = 1'b0;
		fbs = '0;
		diff = '0;
		new_on = 1'b0;
		new_sel = 1'b0;
		d = q;
		d.fb_tick = 1'b0;

		// Bus: one wait cycle, then the access takes effect
		case (q.bus)
			pmlc_pkg::PMLC_BUS_IDLE:
			begin
				if (bus_req)
				begin
					d.bus = pmlc_pkg::PMLC_BUS_ACK;
					d.rdata = rd_mux;
				end
			end
			pmlc_pkg::PMLC_BUS_ACK:
			begin
				d.bus = pmlc_pkg::PMLC_BUS_IDLE;
				// Only a flag that this read returned is cleared; a later set survives
				if (avs_read && reg_idx == pmlc_pkg::PMLC_PLL_CONTROL_IDX &&
					q.rdata[pmlc_pkg::PMLC_CTL_FLAG_BIT])
					d.lock_flag = 1'b0;
				if (wr_ok && reg_idx == pmlc_pkg::PMLC_PLL_CONTROL_IDX)
				begin
					new_on = wd[pmlc_pkg::PMLC_CTL_POWER_BIT];
					new_sel = wd[pmlc_pkg::PMLC_CTL_SEL_BIT];
					if (q.auto_bw)
						d.irq_en = wd[pmlc_pkg::PMLC_CTL_IRQ_EN_BIT];
					// Judged on old values, so a write can switch the loop off and select the VCO together
					if (new_on || !q.vco_sel)
						d.loop_on = new_on;
					if (!new_sel || q.loop_on)
						d.vco_sel = new_sel;
				end
				if (wr_ok && reg_idx == pmlc_pkg::PMLC_BANDWIDTH_CONTROL_IDX)
				begin
					d.auto_bw = wd[pmlc_pkg::PMLC_BW_AUTO_BIT];
					if (!q.auto_bw)
						d.track = wd[pmlc_pkg::PMLC_BW_TRACK_BIT];
				end
				if (wr_ok && reg_idx == pmlc_pkg::PMLC_MULTIPLIER_PROGRAMMING_IDX)
				begin
					d.mul_n = wd[pmlc_pkg::PMLC_N_LSB +: pmlc_pkg::PMLC_NIB_W];
					d.mul_l = wd[pmlc_pkg::PMLC_L_LSB +: pmlc_pkg::PMLC_NIB_W];
				end
			end
			default:
				d.bus = pmlc_pkg::PMLC_BUS_IDLE;
		endcase

		// Zero L kills the loop and the VCO selection
		loop_act = q.loop_on & (q.mul_l != 4'h0);
		if (d.mul_l == 4'h0)
			d.vco_sel = 1'b0;
		if (!d.auto_bw)
			d.irq_en = 1'b0;

		// Modulo divider; zero N counts as one
		n_eff = (q.mul_n == 4'h0) ? 4'h1 : q.mul_n;
		if (!loop_act)
			d.fb_cnt = 4'h0;
		else if (vco_rise)
		begin
			if (q.fb_cnt >= n_eff - 4'h1)
			begin
				d.fb_cnt = 4'h0;
				d.fb_tick = 1'b1;
			end
			else
				d.fb_cnt = q.fb_cnt + 4'h1;
		end

		// Phase-frequency detector: reference edge pumps up, feedback down
		up_n = q.pump_up | ref_rise;
		dn_n = q.pump_down | q.fb_tick;
		if (!loop_act || (up_n && dn_n))
		begin
			d.pump_up = 1'b0;
			d.pump_down = 1'b0;
		end
		else
		begin
			d.pump_up = up_n;
			d.pump_down = dn_n;
		end

		// Lock detector: count feedback ticks over a window of reference edges
		fbs = (q.fb_tick && q.win_fbs != '1) ? q.win_fbs + 1'b1 : q.win_fbs;
		diff = (fbs > LD_WINDOW) ? fbs - LD_WINDOW : LD_WINDOW - fbs;
		if (!loop_act)
		begin
			d.win_refs = '0;
			d.win_fbs = '0;
			if (q.auto_bw)
			begin
				d.track = 1'b0;
				d.lock = 1'b0;
			end
		end
		else if (ref_rise && q.win_refs == LD_WINDOW - 1'b1)
		begin
			// Evaluation rate follows the reference frequency
			d.win_refs = '0;
			d.win_fbs = '0;
			if (q.auto_bw)
			begin
				// Hysteresis between entry and exit bands
				if (diff <= TRK_TOL)
					d.track = 1'b1;
				else if (diff > UNT_TOL)
					d.track = 1'b0;
				if (diff <= LOCK_TOL)
					d.lock = 1'b1;
				else if (diff > UNL_TOL)
					d.lock = 1'b0;
			end
		end
		else
		begin
			d.win_fbs = fbs;
			if (ref_rise)
				d.win_refs = q.win_refs + 1'b1;
		end

		// Manual mode holds lock off
		if (!q.auto_bw)
			d.lock = 1'b0;

		// Lock toggle in auto mode sets the flag; set beats a same-cycle clear
		if (q.auto_bw && d.lock != q.lock)
			d.lock_flag = 1'b1;

		// Center-of-range frequency in Hz
		d.center_hz = pmlc_pkg::PMLC_CENTER_W'(32'(q.mul_l) * pmlc_pkg::PMLC_NOM_FREQ_HZ);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			q <= pmlc_pkg::PMLC_STATE_RST;
		else
			q <= d;
	end

	// Bus handshake
	assign avs_waitrequest = bus_req & (q.bus != pmlc_pkg::PMLC_BUS_ACK);
	assign avs_readdata = q.rdata;

	// Loop side outputs
	assign final_reference_clock = ref_level;
	assign vco_feedback_clock = q.fb_tick;
	assign pump_up = q.pump_up;
	assign pump_down = q.pump_down;
	assign loop_enable = q.loop_on & (q.mul_l != 4'h0);
	assign filter_tracking = loop_enable & q.track;
	assign center_freq_hz = q.center_hz;
	assign base_clock_source_select = q.vco_sel;

	// Interrupt only in auto mode with enable set
	assign lock_change_irq = q.lock_flag & q.irq_en & q.auto_bw;

endmodule

// ### dv/pmlc_loop_ctrl_assertions.sv
// Port checks for the loop mode and lock control block.
// Assumes a master that holds each request until waitrequest drops.
`timescale 1ns/1ps
module pmlc_loop_ctrl_checker
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Register bus
	input wire logic [pmlc_pkg::PMLC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// Loop side
	input wire logic crystal_clock,
	input wire logic final_reference_clock,
	input wire logic vco_feedback_clock,
	input wire logic pump_up,
	input wire logic pump_down,
	input wire logic loop_enable,
	input wire logic [pmlc_pkg::PMLC_CENTER_W-1:0] center_freq_hz,
	input wire logic base_clock_source_select
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Accepted multiplier writes, then those with a zero range factor
	sequence mul_wr_s;
		avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h78;
	endsequence
	sequence l_zero_s;
		mul_wr_s ##0 avs_writedata[3:0] == 4'h0;
	endsequence
	// At most one wait cycle per access
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait");
	read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	center_freq_a: assert property (mul_wr_s |-> ##2
		center_freq_hz == $past(avs_writedata[3:0], 2) * pmlc_pkg::PMLC_NOM_FREQ_HZ)
		else $error("center frequency wrong");
	l_zero_off_a: assert property (l_zero_s |=> !loop_enable ##[0:1] !base_clock_source_select)
		else $error("zero range factor left loop usable");
	vco_sel_loop_a: assert property ($rose(base_clock_source_select) |-> loop_enable)
		else $error("vco selected with loop off");
	fb_pulse_a: assert property (vco_feedback_clock |=> !vco_feedback_clock)
		else $error("feedback pulse too long");
	fb_loop_a: assert property (vco_feedback_clock |-> loop_enable || $past(loop_enable))
		else $error("feedback pulse with loop off");
	pump_excl_a: assert property (!(pump_up && pump_down))
		else $error("both pumps active");
	pump_up_ref_a: assert property ($rose(pump_up) |->
		$past(final_reference_clock) && !$past(final_reference_clock, 2))
		else $error("pump up without reference edge");
	ref_follow_a: assert property ($rose(final_reference_clock) |-> $past(crystal_clock, 2))
		else $error("reference clock not following crystal");
endmodule

// ### dv/test_pmlc_loop_ctrl.sv
// Self-checking bench for the loop control block, driving the bus directly.
// Assumes one wait per access and both clock pins at an eighth of ref_clk.
`timescale 1ns/1ps
module test_pmlc_loop_ctrl;
	localparam int WAIT_MAX = 50;
	localparam int unsigned NOM = pmlc_pkg::PMLC_NOM_FREQ_HZ;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic crystal_clock = 1'b0;
	logic vco_clock = 1'b0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, final_reference_clock, vco_feedback_clock, pump_up, pump_down;
	logic filter_tracking, loop_enable, base_clock_source_select, lock_change_irq;
	logic [26:0] center_freq_hz;
	logic [2:0] tick = 3'h0;
	logic [7:0] q;
	logic [3:0] nv [2] = '{4'h0, 4'h3};
	int ev [2] = '{30, 10};
	int failures = 0;
	int samples_checked = 0;
	int pulses = 0;
	int p0;
	int ups = 0;
	int downs = 0;
	int u0;
	int d0;
	pmlc_loop_ctrl #(.LD_WINDOW(8'h08)) i_dut (.ref_clk, .nrst, .avs_address, .avs_read,
		.avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.crystal_clock, .vco_clock, .final_reference_clock, .vco_feedback_clock, .pump_up,
		.pump_down, .filter_tracking, .loop_enable, .center_freq_hz,
		.base_clock_source_select, .lock_change_irq);
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Same-rate pins so feedback matches reference when N is one
	always @(posedge ref_clk)
	begin
		tick <= tick + 3'h1;
		crystal_clock <= tick[2];
		vco_clock <= tick[2];
		if (vco_feedback_clock === 1'b1)
			pulses <= pulses + 1;
		if (pump_up === 1'b1)
			ups <= ups + 1;
		if (pump_down !== 1'b0)
			downs <= downs + 1;
	end
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// One access; idle edge first so a strobe is never re-raised in the same step
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do
		begin
			@(posedge ref_clk);
			i++;
		end
		while (avs_waitrequest !== 1'b0 && i < WAIT_MAX);
		if (avs_waitrequest !== 1'b0)
		begin
			failures++;
			print_verdict();
		end
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(n, {24'h0, e}, {24'h0, q});
	endtask
	initial
	begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		for (int k = 0; k < 4; k++)
			rchk("reset value", 8'h70 + 8'(k * 4), 8'h00);
		bus(1'b1, 8'h78, 8'ha5);
		rchk("multiplier", 8'h78, 8'ha5);
		chk("center", NOM * 5, {5'h0, center_freq_hz});
		bus(1'b1, 8'h70, 8'h10);
		rchk("select with loop off", 8'h70, 8'h00);
		bus(1'b1, 8'h74, 8'h20);
		rchk("manual track", 8'h74, 8'h20);
		bus(1'b1, 8'h74, 8'h00);
		bus(1'b1, 8'h70, 8'ha0);
		rchk("manual irq enable", 8'h70, 8'h20);
		repeat (100) @(posedge ref_clk);
		bus(1'b1, 8'h74, 8'h20);
		rchk("manual lock", 8'h74, 8'h20);
		chk("tracking", 1, filter_tracking);
		repeat (100) @(posedge ref_clk);
		bus(1'b1, 8'h70, 8'h30);
		bus(1'b1, 8'h70, 8'h10);
		rchk("loop off refused", 8'h70, 8'h30);
		chk("manual irq", 0, lock_change_irq);
		// Feedback pulses over thirty vco rises, N of zero acting as one
		for (int k = 0; k < 2; k++)
		begin
			bus(1'b1, 8'h78, {nv[k], 4'h1});
			repeat (16) @(posedge ref_clk);
			p0 = pulses;
			u0 = ups;
			d0 = downs;
			repeat (240) @(posedge ref_clk);
			chk("feedback pulses", 1, pulses - p0 >= ev[k] - 1 && pulses - p0 <= ev[k] + 1);
			chk("pump up", 1, ups - u0 >= ev[k] - 1);
			chk("pump down", 0, downs - d0);
		end
		bus(1'b1, 8'h78, 8'h10);
		repeat (2) @(posedge ref_clk);
		chk("loop enable", 0, loop_enable);
		bus(1'b0, 8'h70, 8'h00);
		chk("forced crystal", 0, q[4]);
		bus(1'b1, 8'h78, 8'h11);
		bus(1'b1, 8'h74, 8'h80);
		bus(1'b1, 8'h70, 8'ha0);
		repeat (400) @(posedge ref_clk);
		rchk("auto lock", 8'h74, 8'he0);
		chk("irq raised", 1, lock_change_irq);
		rchk("flag", 8'h70, 8'he0);
		rchk("flag cleared", 8'h70, 8'ha0);
		repeat (2) @(posedge ref_clk);
		chk("irq cleared", 0, lock_change_irq);
		bus(1'b1, 8'h70, 8'hb0);
		rchk("vco selected", 8'h70, 8'hb0);
		bus(1'b1, 8'h78, 8'h31);
		repeat (400) @(posedge ref_clk);
		rchk("lock lost", 8'h74, 8'h80);
		chk("irq on loss", 1, lock_change_irq);
		print_verdict();
	end
endmodule
bind pmlc_loop_ctrl pmlc_loop_ctrl_checker i_chk (.ref_clk, .nrst, .avs_address, .avs_read,
	.avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.crystal_clock, .final_reference_clock, .vco_feedback_clock, .pump_up, .pump_down,
	.loop_enable, .center_freq_hz, .base_clock_source_select);
